// ===== pbc_control.sv
// What this block does
// R1: While isolated the device ignores the MII transmit nibble, transmit enable and transmit error.
// R2: While isolated the MII clock, receive, collision and carrier outputs toward the MAC float.
// R3: While isolated the enabled 25 MHz reference clock keeps running and management access still works.
// R4: While isolated the twisted pair output sends idles, serial outputs float, receive inputs are ignored, link is off.
// R5: The isolate bit is read-write and comes up set after reset only when the strapped PHY address is all zero.
// R6: Writing one to restart starts negotiation again, but does nothing while negotiation is disabled.
// R7: The restart bit reads one after being set and clears itself once negotiation has actually begun (here also when negotiation is disabled).
// R8: Writing zero to restart while negotiation is pending leaves the negotiation undisturbed.
// R9: The duplex bit, default one, selects full or half duplex and only counts while negotiation is disabled.
// R10: The duplex bit reads back what was written, never the operating duplex.
// R11: With collision test set, collision is asserted whenever the MAC asserts transmit enable.
// R12: Bits 6 to 0 are reserved read-only, software writes zero and the device returns zero.
// R13: With negotiation disabled the duplex and speed bits fix the link speed and duplex.
// R14: Clearing isolate returns the MII and line paths to normal and re-enables the link without a reset.
/*
  Lower half (bits 10 to 0) of the basic mode control register, with the
  isolate gate and the restart controller it steers.
  Assumes bits 15 to 11 are held by a neighbouring block and arrive on
  ctrl_upper, the negotiation engine reports its result and start, and
  management accesses come from the serial management frame decoder.
*/
`timescale 1ns/1ps
module pbc_control #(
  parameter int                PHY_ADDR_W  = 5,
  parameter int                LINE_W      = 5,
  parameter logic [LINE_W-1:0] IDLE_SYMBOL = '1
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [PHY_ADDR_W-1:0]     strapped_phy_address,
  input  wire pbc_pkg::pbc_mgmt_req_type mgmt_req,
  input  wire logic [4:0]                ctrl_upper,
  input  wire logic                      an_full_duplex,
  input  wire logic                      an_speed_100,
  input  wire logic                      an_initiated,
  input  wire pbc_pkg::pbc_mii_tx_type   mii_tx_in,
  input  wire pbc_pkg::pbc_mii_rx_type   core_rx,
  input  wire logic [LINE_W-1:0]         core_tp_tx,
  input  wire logic                      core_serial_tx,
  input  wire logic                      twisted_pair_rx_input,
  input  wire logic                      serial_rx_input,
  input  wire logic                      ref_clock_25_core,
  input  wire logic                      ref_clock_25_enable,
  output logic [15:0]                    mgmt_rdata,
  output logic                           an_restart,
  output logic                           link_full_duplex,
  output logic                           link_speed_100,
  output logic                           isolated,
  output pbc_pkg::pbc_mii_tx_type        core_tx,
  output pbc_pkg::pbc_mii_rx_type        mii_rx_out,
  output pbc_pkg::pbc_mii_rx_type        mii_rx_oe,
  output logic [LINE_W-1:0]              twisted_pair_tx_output,
  output logic                           serial_tx_output_a,
  output logic                           serial_tx_output_a_oe,
  output logic                           serial_tx_output_b,
  output logic                           serial_tx_output_b_oe,
  output logic                           core_tp_rx,
  output logic                           core_serial_rx,
  output logic                           link_enable,
  output logic                           ref_clock_25_output,
  output logic                           ref_clock_25_output_oe
);
  import pbc_pkg::*;

  if (PHY_ADDR_W != 5) begin : g_bad_addr
    $error("PHY_ADDR_W must be 5");
  end

  // Control bits of this half
  logic isolate;
  logic duplex;
  logic col_test;
  logic strap_taken;
  logic restart_bit;

  // Decode of one management access
  function automatic logic hits_control(input pbc_mgmt_req_type req);
    hits_control = (req.addr == PBC_ADDR_CONTROL);
  endfunction

  wire ctrl_wr      = mgmt_req.wr && hits_control(mgmt_req);
  wire an_enable    = ctrl_upper[PBC_BIT_AN_ENABLE - PBC_UPPER_LSB];
  wire speed_bit    = ctrl_upper[PBC_BIT_SPEED - PBC_UPPER_LSB];
  wire strap_zero   = (strapped_phy_address == PBC_ISOLATE_STRAP);
  wire wr_restart_1 = ctrl_wr && mgmt_req.wdata[PBC_BIT_RESTART];
  wire wr_restart_0 = ctrl_wr && !mgmt_req.wdata[PBC_BIT_RESTART];

  // Reserved bits are not stored; they read as zero
  wire [15:0] ctrl_view = {ctrl_upper, isolate, restart_bit, duplex, col_test, PBC_RSVD_READ}; // [R10] [R12]
  wire [15:0] next_rdata = hits_control(mgmt_req) ? ctrl_view : PBC_UNMAPPED_READ;

  // Operating mode: register bits when negotiation is off, engine result otherwise
  wire next_full_duplex = an_enable ? an_full_duplex : duplex;                     // [R9] [R13]
  wire next_speed_100   = an_enable ? an_speed_100 : speed_bit;                    // [R13]

  // Strap is caught on the first edge after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      isolate     <= PBC_RST_ISOLATE;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      isolate     <= strap_zero;                                                   // [R5]
    end else if (ctrl_wr) begin
      isolate     <= mgmt_req.wdata[PBC_BIT_ISOLATE];                              // [R5] [R14]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duplex   <= PBC_RST_DUPLEX;
      col_test <= PBC_RST_COL_TEST;
    end else if (ctrl_wr && strap_taken) begin
      duplex   <= mgmt_req.wdata[PBC_BIT_DUPLEX];                                  // [R9]
      col_test <= mgmt_req.wdata[PBC_BIT_COL_TEST];                                // [R11]
    end
  end

  // Management reads are answered in and out of isolation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata       <= PBC_UNMAPPED_READ;
      link_full_duplex <= PBC_RST_DUPLEX;
      link_speed_100   <= 1'b0;
      isolated         <= PBC_RST_ISOLATE;
    end else begin
      mgmt_rdata       <= next_rdata;                                              // [R3]
      link_full_duplex <= next_full_duplex;                                        // [R9] [R13]
      link_speed_100   <= next_speed_100;                                          // [R13]
      isolated         <= isolate;
    end
  end

  pbc_restart u_restart (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .wr_one       (wr_restart_1 && strap_taken),
    .wr_zero      (wr_restart_0),
    .an_enable    (an_enable),
    .an_initiated (an_initiated),
    .restart_bit  (restart_bit),
    .an_restart   (an_restart)
  );

  pbc_mii_gate #(
    .LINE_W      (LINE_W),
    .IDLE_SYMBOL (IDLE_SYMBOL)
  ) u_gate (
    .ref_clk                (ref_clk),
    .rst_n                  (rst_n),
    .isolate                (isolate),
    .col_test               (col_test),
    .mii_tx_in              (mii_tx_in),
    .core_rx                (core_rx),
    .core_tp_tx             (core_tp_tx),
    .core_serial_tx         (core_serial_tx),
    .twisted_pair_rx_input  (twisted_pair_rx_input),
    .serial_rx_input        (serial_rx_input),
    .ref_clock_25_core      (ref_clock_25_core),
    .ref_clock_25_enable    (ref_clock_25_enable),
    .core_tx                (core_tx),
    .mii_rx_out             (mii_rx_out),
    .mii_rx_oe              (mii_rx_oe),
    .twisted_pair_tx_output (twisted_pair_tx_output),
    .serial_tx_output_a     (serial_tx_output_a),
    .serial_tx_output_a_oe  (serial_tx_output_a_oe),
    .serial_tx_output_b     (serial_tx_output_b),
    .serial_tx_output_b_oe  (serial_tx_output_b_oe),
    .core_tp_rx             (core_tp_rx),
    .core_serial_rx         (core_serial_rx),
    .link_enable            (link_enable),
    .ref_clock_25_output    (ref_clock_25_output),
    .ref_clock_25_output_oe (ref_clock_25_output_oe)
  );

  sequence s_ctrl_write;
    ctrl_wr && strap_taken;
  endsequence

  a_strap_isolate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(strap_taken) |-> isolate == $past(strap_zero) ##1 isolated == $past(isolate)) // [R5]
    else $error("isolate did not follow the strap after reset");

  a_isolate_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write |=> isolate == $past(mgmt_req.wdata[PBC_BIT_ISOLATE]))          // [R5]
    else $error("isolate bit not written");

  a_isolate_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write and mgmt_req.wdata[PBC_BIT_ISOLATE] |=> ##1 mii_rx_oe == '0 && !link_enable) // [R2] [R4]
    else $error("isolate write did not release pins in two cycles");

  a_duplex_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !an_enable && !ctrl_wr |=> link_full_duplex == duplex)                       // [R9] [R13]
    else $error("duplex bit ignored with negotiation off");

  a_duplex_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    an_enable |=> link_full_duplex == $past(an_full_duplex) && link_speed_100 == $past(an_speed_100)) // [R9]
    else $error("register bits used while negotiating");

  a_duplex_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hits_control(mgmt_req) && !ctrl_wr |=> mgmt_rdata[PBC_BIT_DUPLEX] == duplex) // [R10]
    else $error("duplex read does not show the written bit");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hits_control(mgmt_req) |=> mgmt_rdata[PBC_RSVD_W-1:0] == PBC_RSVD_READ)       // [R12]
    else $error("reserved bits read nonzero");

  a_read_isolated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isolate && hits_control(mgmt_req) && !ctrl_wr |=> mgmt_rdata[PBC_BIT_ISOLATE]) // [R3]
    else $error("management read failed while isolated");

  a_coltest_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write ##1 (!isolate && mii_tx_in.tx_en && col_test) |=> mii_rx_out.col) // [R11]
    else $error("collision test bit not effective");

endmodule

// ===== pbc_control_bench.sv
/* Register and pin tests of pbc_control via its management port.
   Assumes writes are one-cycle strobes and reads answer next cycle. */
`timescale 1ns/1ps
module pbc_control_bench;
  import pbc_pkg::*;
  logic             rc, rn, afd, asp, cst, tprx, srx, r25c, r25e, ai;
  logic [4:0]       strap, up, ctp, tpo;
  logic [3:0]       lat;
  pbc_mgmt_req_type req;
  pbc_mii_tx_type   tx, ctx;
  pbc_mii_rx_type   crx, rxo, rxoe;
  logic [15:0]      rd;
  logic             rst, lfd, lsp, iso, sa, saoe, sb, sboe, ctprx, csrx, len, r25o, r25oe;
  int               mismatches, tests_run;
  pbc_control u_pbc_control (.ref_clk(rc), .rst_n(rn), .strapped_phy_address(strap), .mgmt_req(req),
    .ctrl_upper(up), .an_full_duplex(afd), .an_speed_100(asp), .an_initiated(ai), .mii_tx_in(tx),
    .core_rx(crx), .core_tp_tx(ctp), .core_serial_tx(cst), .twisted_pair_rx_input(tprx),
    .serial_rx_input(srx), .ref_clock_25_core(r25c), .ref_clock_25_enable(r25e), .mgmt_rdata(rd),
    .an_restart(rst), .link_full_duplex(lfd), .link_speed_100(lsp), .isolated(iso), .core_tx(ctx),
    .mii_rx_out(rxo), .mii_rx_oe(rxoe), .twisted_pair_tx_output(tpo), .serial_tx_output_a(sa),
    .serial_tx_output_a_oe(saoe), .serial_tx_output_b(sb), .serial_tx_output_b_oe(sboe),
    .core_tp_rx(ctprx), .core_serial_rx(csrx), .link_enable(len), .ref_clock_25_output(r25o),
    .ref_clock_25_output_oe(r25oe));
  pbc_engine_model u_pbc_engine_model (.ref_clk(rc), .rst_n(rn), .an_restart(rst), .lat(lat),
    .an_initiated(ai));
  initial begin
    rc = 0;
    forever #2.5 rc = ~rc;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reserved bits always written as zero
  task wr(input logic [15:0] d);
    req = '{1'b1, PBC_ADDR_CONTROL, d};
    @(posedge rc) #1 req.wr = 1'b0;
  endtask
  task rdv(input logic [4:0] a, input logic [15:0] e);
    if (req.addr !== a) req.addr = a;
    @(posedge rc) #1 chk(rd, e);
  endtask
  task do_reset;
    rn = 0;
    repeat (12) @(posedge rc);
    #1 rn = 1;
    @(posedge rc) #1;
  endtask
  initial begin
    #30000 mismatches++;
    tally_and_finish;
  end
  initial begin
    req = '0; afd = 0; asp = 0; cst = 1; tprx = 1; srx = 1; r25c = 1; r25e = 1;
    strap = 5'h01; up = 5'h02; ctp = 5'h0a; lat = 4'h8; tx = '0; crx = 10'h155;
    do_reset;
    rdv(5'h00, 16'h1100);
    rdv(5'h01, 16'h0000);
    chk({15'h0, lfd}, 16'h0000);
    $display("test reset done");
    up = 5'h00;
    tx.tx_en = 1;
    wr(16'h0080);
    rdv(5'h00, 16'h0080);
    chk({14'h0, lfd, lsp}, 16'h0000);
    up = 5'h04;
    repeat (2) @(posedge rc) #1;
    chk({14'h0, lfd, lsp}, 16'h0001);
    chk({6'h0, rxo}, {6'h0, crx | 10'h002});
    $display("test duplex and collision done");
    tx = 6'h3f;
    wr(16'h0480);
    repeat (2) @(posedge rc) #1;
    chk({6'h0, rxoe}, 16'h0000);
    chk({12'h0, sa, sb, r25o, iso}, 16'h000b);
    chk({10'h0, ctx}, 16'h0000);
    chk({11'h0, tpo}, 16'h001f);
    chk({10'h0, saoe, sboe, len, ctprx, csrx, r25oe}, 16'h0001);
    rdv(5'h00, 16'h2480);
    wr(16'h0000);
    repeat (2) @(posedge rc) #1;
    chk({6'h0, rxoe}, 16'h03ff);
    chk({6'h0, rxo}, {6'h0, crx});
    chk({10'h0, ctx}, 16'h003f);
    chk({11'h0, saoe, sboe, len, ctprx, csrx}, 16'h001f);
    chk({11'h0, tpo}, 16'h000a);
    chk({12'h0, sa, sb, r25o, iso}, 16'h000a);
    $display("test isolate done");
    up = 5'h02;
    wr(16'h0200);
    chk({15'h0, rst}, 16'h0001);
    @(posedge rc) #1;
    chk({15'h0, rst}, 16'h0000);
    wr(16'h0000);
    rdv(5'h00, 16'h1200);
    repeat (12) @(posedge rc) #1;
    rdv(5'h00, 16'h1000);
    up = 5'h00;
    wr(16'h0200);
    chk({15'h0, rst}, 16'h0000);
    rdv(5'h00, 16'h0000);
    $display("test restart done");
    strap = 5'h00;
    do_reset;
    @(posedge rc) #1;
    rdv(5'h00, 16'h0500);
    $display("test strap done");
    tally_and_finish;
  end
endmodule

// ===== pbc_engine_model.sv
/* Negotiation engine stand-in: one-cycle start report lat+1 cycles
   after each restart pulse. Assumes the pbc_control restart handshake. */
`timescale 1ns/1ps
module pbc_engine_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       an_restart,
  input  wire logic [3:0] lat,
  output logic            an_initiated
);
  logic [4:0] cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt <= 5'h00;
    else if (an_restart) cnt <= {1'b0, lat} + 5'h01;
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  end
  assign an_initiated = (cnt == 5'h01);
endmodule

// ===== pbc_mii_gate.sv
/*
  Isolation gate between the PHY core and its pins: MII outputs and
  their enables, MII transmit inputs, line transmit and receive paths,
  link enable, collision test and the 25 MHz reference clock output.
  Assumes the isolate and collision test controls come from flip-flops.
*/
`timescale 1ns/1ps
module pbc_mii_gate #(
  parameter int               LINE_W      = 5,
  parameter logic [LINE_W-1:0] IDLE_SYMBOL = '1
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  isolate,
  input  wire logic                  col_test,
  input  wire pbc_pkg::pbc_mii_tx_type mii_tx_in,
  input  wire pbc_pkg::pbc_mii_rx_type core_rx,
  input  wire logic [LINE_W-1:0]     core_tp_tx,
  input  wire logic                  core_serial_tx,
  input  wire logic                  twisted_pair_rx_input,
  input  wire logic                  serial_rx_input,
  input  wire logic                  ref_clock_25_core,
  input  wire logic                  ref_clock_25_enable,
  output pbc_pkg::pbc_mii_tx_type    core_tx,
  output pbc_pkg::pbc_mii_rx_type    mii_rx_out,
  output pbc_pkg::pbc_mii_rx_type    mii_rx_oe,
  output logic [LINE_W-1:0]          twisted_pair_tx_output,
  output logic                       serial_tx_output_a,
  output logic                       serial_tx_output_a_oe,
  output logic                       serial_tx_output_b,
  output logic                       serial_tx_output_b_oe,
  output logic                       core_tp_rx,
  output logic                       core_serial_rx,
  output logic                       link_enable,
  output logic                       ref_clock_25_output,
  output logic                       ref_clock_25_output_oe
);
  import pbc_pkg::*;

  if (LINE_W < 1) begin : g_bad_width
    $error("LINE_W must be at least 1");
  end

  wire                 next_col    = core_rx.col | (col_test & mii_tx_in.tx_en);          // [R11]
  wire pbc_mii_rx_type next_mii_rx = {core_rx.tx_clk, core_rx.rx_clk, core_rx.rx_dv,
                                      core_rx.rx_er, core_rx.rxd, next_col, core_rx.crs};
  wire pbc_mii_tx_type next_core_tx = isolate ? pbc_mii_tx_type'(0) : mii_tx_in;          // [R1]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_tx                <= '0;
      mii_rx_out             <= '0;
      mii_rx_oe              <= '0;
      twisted_pair_tx_output <= '1;
      serial_tx_output_a     <= 1'b0;
      serial_tx_output_a_oe  <= 1'b0;
      serial_tx_output_b     <= 1'b0;
      serial_tx_output_b_oe  <= 1'b0;
      core_tp_rx             <= 1'b0;
      core_serial_rx         <= 1'b0;
      link_enable            <= 1'b0;
      ref_clock_25_output    <= 1'b0;
      ref_clock_25_output_oe <= 1'b0;
    end else begin
      core_tx                <= next_core_tx;                                             // [R1]
      mii_rx_out             <= next_mii_rx;
      mii_rx_oe              <= isolate ? '0 : '1;                                        // [R2] [R14]
      twisted_pair_tx_output <= isolate ? IDLE_SYMBOL : core_tp_tx;                       // [R4]
      serial_tx_output_a     <= core_serial_tx;
      serial_tx_output_a_oe  <= !isolate;                                                 // [R4]
      serial_tx_output_b     <= !core_serial_tx;
      serial_tx_output_b_oe  <= !isolate;                                                 // [R4]
      core_tp_rx             <= !isolate && twisted_pair_rx_input;                        // [R4]
      core_serial_rx         <= !isolate && serial_rx_input;                              // [R4]
      link_enable            <= !isolate;                                                 // [R4] [R14]
      ref_clock_25_output    <= ref_clock_25_core && ref_clock_25_enable;                 // [R3]
      ref_clock_25_output_oe <= ref_clock_25_enable;                                      // [R3]
    end
  end

  a_tx_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isolate |=> core_tx == '0)                                                             // [R1]
    else $error("transmit inputs passed while isolated");

  a_pins_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isolate |=> mii_rx_oe == '0 && !serial_tx_output_a_oe && !serial_tx_output_b_oe)       // [R2]
    else $error("pins driven while isolated");

  a_line_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isolate |=> twisted_pair_tx_output == IDLE_SYMBOL && !link_enable && !core_tp_rx && !core_serial_rx) // [R4]
    else $error("line side active while isolated");

  a_clock_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    isolate && ref_clock_25_enable |=> ref_clock_25_output_oe)                             // [R3]
    else $error("reference clock stopped by isolation");

  a_rejoin_normal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(isolate) |=> mii_rx_oe == '1 && link_enable && serial_tx_output_a_oe)            // [R14]
    else $error("leaving isolation did not restore pins");

  a_col_forced: assert property (@(posedge ref_clk) disable iff (!rst_n)
    col_test && mii_tx_in.tx_en |=> mii_rx_out.col)                                        // [R11]
    else $error("collision test did not raise collision");

endmodule

// ===== pbc_pkg.sv
/*
  Shared constants and carriers for the lower half of the PHY basic mode
  control register: bit positions, reset values, MII pin groups, the
  management access record and the restart state encoding.
  Assumes a single 200 MHz device clock and a parallel management access
  port fed by the serial management frame decoder.
*/
package pbc_pkg;

  // Register map
  localparam logic [4:0]  PBC_ADDR_CONTROL     = 5'h00;
  localparam int          PBC_DATA_W           = 16;

  // Field positions
  localparam int          PBC_BIT_SPEED        = 13;
  localparam int          PBC_BIT_AN_ENABLE    = 12;
  localparam int          PBC_UPPER_LSB        = 11;
  localparam int          PBC_UPPER_W          = 5;
  localparam int          PBC_BIT_ISOLATE      = 10;
  localparam int          PBC_BIT_RESTART      = 9;
  localparam int          PBC_BIT_DUPLEX       = 8;
  localparam int          PBC_BIT_COL_TEST     = 7;
  localparam int          PBC_RSVD_W           = 7;

  // Reset values
  localparam logic        PBC_RST_ISOLATE      = 1'b0;
  localparam logic        PBC_RST_RESTART      = 1'b0;
  localparam logic        PBC_RST_DUPLEX       = 1'b1;
  localparam logic        PBC_RST_COL_TEST     = 1'b0;
  localparam logic [4:0]  PBC_ISOLATE_STRAP    = 5'h00;
  localparam logic [6:0]  PBC_RSVD_READ        = 7'h00;
  localparam logic [15:0] PBC_UNMAPPED_READ    = 16'h0000;

  // Transmit inputs from the MAC
  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
  } pbc_mii_tx_type;

  // Outputs toward the MAC, one bit per pin
  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
    logic       col;
    logic       crs;
  } pbc_mii_rx_type;

  // One management access, wr high for one cycle on a write
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pbc_mgmt_req_type;

  typedef enum logic [1:0] {
    PBC_RS_IDLE  = 2'b00,
    PBC_RS_ISSUE = 2'b01,
    PBC_RS_WAIT  = 2'b10
  } pbc_restart_state_type;

endpackage

// ===== pbc_restart.sv
/*
  Self-clearing restart of auto-negotiation: takes a write of one,
  issues a one-cycle restart pulse to the negotiation engine and holds
  the readable bit until the engine reports that it has started or negotiation is disabled.
  Assumes the engine raises an_initiated once per restart it begins.
*/
`timescale 1ns/1ps
module pbc_restart (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic wr_one,
  input  wire logic wr_zero,
  input  wire logic an_enable,
  input  wire logic an_initiated,
  output logic      restart_bit,
  output logic      an_restart
);
  import pbc_pkg::*;

  pbc_restart_state_type state;
  pbc_restart_state_type next_state;

  wire go         = wr_one && an_enable;
  wire from_idle  = (state == PBC_RS_IDLE) && go;
  wire rearm      = (state != PBC_RS_IDLE) && an_initiated && go;

  always_comb begin
    case (state)
      PBC_RS_IDLE:  next_state = go ? PBC_RS_ISSUE : PBC_RS_IDLE;                 // [R6]
      PBC_RS_ISSUE: next_state = rearm ? PBC_RS_ISSUE :
                                 (an_initiated ? PBC_RS_IDLE : PBC_RS_WAIT);       // [R7]
      PBC_RS_WAIT: begin
        if (rearm) begin
          next_state = PBC_RS_ISSUE;
        end else if (an_initiated || !an_enable) begin
          next_state = PBC_RS_IDLE;                                               // [R7]
        end else begin
          next_state = PBC_RS_WAIT;                                               // [R8]
        end
      end
      default:      next_state = PBC_RS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= PBC_RS_IDLE;
      restart_bit <= PBC_RST_RESTART;
      an_restart  <= 1'b0;
    end else begin
      state       <= next_state;
      restart_bit <= (next_state != PBC_RS_IDLE);
      an_restart  <= from_idle || rearm;
    end
  end

  sequence s_request;
    (state == PBC_RS_IDLE) && wr_one && an_enable;
  endsequence

  sequence s_pending;
    restart_bit && an_enable && !an_initiated;
  endsequence

  a_restart_issue: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_request |=> an_restart && restart_bit ##1 !an_restart)                     // [R6]
    else $error("restart write did not issue one pulse");

  a_restart_noop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == PBC_RS_IDLE) && wr_one && !an_enable |=> !restart_bit && !an_restart) // [R6]
    else $error("restart acted with negotiation disabled");

  a_restart_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pending |=> restart_bit)                                                   // [R7]
    else $error("restart bit cleared before negotiation began");

  a_zero_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pending and wr_zero |=> restart_bit && !an_restart)                       // [R8]
    else $error("write of zero disturbed a pending restart");

  a_restart_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    restart_bit && an_initiated && !wr_one |=> !restart_bit)                     // [R7]
    else $error("restart bit did not self clear");

endmodule
